//--- bus_area_config.sv
/*
  APB register bank for the external bus area configuration: memory types,
  burst, card space, widths, idle cycles, pin float control, wait sampling.
  Assumes rst is the power-on reset; manual reset and standby are inputs
  that never clear the registers. One clock; bus clock is derived by a
  divide-by-two enable.
*/
// Register access over APB and the address map were chosen for this implementation.
// Overview of operation
// RULE1 - Memory pins float in standby unless driven
// RULE2 - Float covers address, strobes, selects, mode pins
// RULE3 - Row/column strobes float in standby/bus release
// RULE4 - Byte-order flag captures strap at power-on
// RULE5 - Flag zero big-endian, one little-endian
// RULE6 - Area 0 burst field selects burst length
// RULE7 - Area 5 burst field selects burst length
// RULE8 - Area 6 burst field selects burst length
// RULE9 - Area 2/3 memory type decode, two reserved
// RULE10 - Both DRAM: strap pin becomes second row strobe
// RULE11 - Area 5 card space drives card enable A
// RULE12 - Area 6 card space drives card enable B
// RULE13 - Area control clears only on power-on reset
// RULE14 - Width register loads 3FFC on power-on only
// RULE15 - Software configures widths before other areas
// RULE16 - Width field decode, reserved codes
// RULE17 - Port enable frees upper data byte
// RULE18 - Reserved width bits read zero
// RULE19 - Idle states between differing accesses
// RULE20 - Idle field gives one, two or three
// RULE21 - Idle register loads 3FFF on power-on only
// RULE22 - Wait select zero samples on rising edge
// RULE23 - Wait select one samples on falling edge
// RULE24 - Read-only and reserved bits ignore writes
`timescale 1ns/1ps
module bus_area_config (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        manualReset,
  input  wire logic        standby,
  input  wire logic        busReleased,
  input  wire logic        byteOrderStrapPin,
  input  wire logic        waitIn,
  input  wire logic        accessReq,
  input  wire logic [2:0]  accessArea,
  input  wire logic        accessWrite,
  output logic             accessGrant,
  output logic             busClockOut,
  output logic             waitSampled,
  output logic             memPinsOe,
  output logic             dramStrobeOe,
  output logic             bigEndian,
  output logic             strapIsSecondRowStrobe,
  output logic             thirdModePinIsCardEnableA,
  output logic             fourthModePinIsCardEnableB,
  output logic [4:0]       area0BurstLen,
  output logic [4:0]       area5BurstLen,
  output logic [4:0]       area6BurstLen,
  output logic [2:0]       area23MemType,
  output logic [11:0]      areaWidths,
  output logic             upperDataPortEn,
  output logic             configError
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] busAreaControl;
    logic [15:0] busWidthSelect;
    logic [15:0] idleCycleControl;
    logic        byteOrder;
    logic        strapTaken;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        busClk;
    logic        waitSmp;
    logic        memOe;
    logic        dramOe;
    logic        bigEnd;
    logic        secondRas;
    logic        ceA;
    logic        ceB;
    logic [4:0]  burst0;
    logic [4:0]  burst5;
    logic [4:0]  burst6;
    logic [2:0]  memType;
    logic [11:0] widths;
    logic        upper_data_port_en;
    logic        cfgErr;
  } bank_t;

  bank_t cur;
  bank_t next_cur;

  logic        setup;
  logic        wrEn;
  logic [15:0] ctrlView;
  logic        risingEn;
  logic        fallingEn;
  logic        badCfg;
  logic [1:0]  w;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    setup = psel && !penable;
    wrEn = psel && penable && cur.ready && pwrite;
    ctrlView = cur.busAreaControl;
    ctrlView[bus_area_config_pkg::BIT_BYTE_ORDER] = cur.byteOrder; // see RULE5

    // Strap caught once, first edge after power-on release
    if (!cur.strapTaken) begin
      next_cur.byteOrder = byteOrderStrapPin; // see RULE4
      next_cur.strapTaken = 1'b1;
    end

    // Register writes; manual reset and standby never clear, see RULE13
    if (wrEn) begin
      case (paddr)
        bus_area_config_pkg::OFS_BUS_AREA_CONTROL:
          next_cur.busAreaControl = pwdata[15:0]
            & bus_area_config_pkg::MASK_BUS_AREA_CONTROL; // see RULE24
        bus_area_config_pkg::OFS_BUS_WIDTH_SELECT:
          next_cur.busWidthSelect = pwdata[15:0]
            & bus_area_config_pkg::MASK_BUS_WIDTH_SELECT; // see RULE18
        bus_area_config_pkg::OFS_IDLE_CYCLE_CONTROL:
          next_cur.idleCycleControl = pwdata[15:0]
            & bus_area_config_pkg::MASK_IDLE_CYCLE_CONTROL; // see RULE24
        default: next_cur.err = cur.err;
      endcase
    end

    // APB answer: ready in the access phase after setup
    next_cur.ready = setup;
    next_cur.err = 1'b0;
    next_cur.rdata = 32'h0000_0000;
    if (setup) begin
      case (paddr)
        bus_area_config_pkg::OFS_BUS_AREA_CONTROL:
          next_cur.rdata = {16'h0000, ctrlView};
        bus_area_config_pkg::OFS_BUS_WIDTH_SELECT:
          next_cur.rdata = {16'h0000, cur.busWidthSelect}; // see RULE18
        bus_area_config_pkg::OFS_IDLE_CYCLE_CONTROL:
          next_cur.rdata = {16'h0000, cur.idleCycleControl};
        default: next_cur.err = 1'b1;
      endcase
    end

    // Bus clock divider and wait sampling edge
    next_cur.busClk = !cur.busClk;
    risingEn = !cur.busClk;
    fallingEn = cur.busClk;
    if (cur.idleCycleControl[bus_area_config_pkg::BIT_WAIT_EDGE]) begin
      if (fallingEn) begin
        next_cur.waitSmp = waitIn; // see RULE23
      end
    end else begin
      if (risingEn) begin
        next_cur.waitSmp = waitIn; // see RULE22
      end
    end

    // Pin float control
    next_cur.memOe = !standby
      || cur.busAreaControl[bus_area_config_pkg::BIT_MEM_FLOAT]; // see RULE1 RULE2
    next_cur.dramOe = !(standby || busReleased)
      || cur.busAreaControl[bus_area_config_pkg::BIT_DRAM_FLOAT]; // see RULE3

    // Decoded configuration
    next_cur.bigEnd = !cur.byteOrder; // see RULE5
    next_cur.memType = cur.busAreaControl[bus_area_config_pkg::POS_AREA23_TYPE +: 3]; // see RULE9
    next_cur.secondRas = (next_cur.memType == bus_area_config_pkg::TYPE_BOTH_DRAM); // see RULE10
    next_cur.ceA = cur.busAreaControl[bus_area_config_pkg::BIT_AREA5_CARD]; // see RULE11
    next_cur.ceB = cur.busAreaControl[bus_area_config_pkg::BIT_AREA6_CARD]; // see RULE12
    next_cur.burst0 = bus_area_config_pkg::burst_len(
      cur.busAreaControl[bus_area_config_pkg::POS_AREA0_BURST +: 2]); // see RULE6
    next_cur.burst5 = bus_area_config_pkg::burst_len(
      cur.busAreaControl[bus_area_config_pkg::POS_AREA5_BURST +: 2]); // see RULE7
    next_cur.burst6 = bus_area_config_pkg::burst_len(
      cur.busAreaControl[bus_area_config_pkg::POS_AREA6_BURST +: 2]); // see RULE8
    next_cur.widths = cur.busWidthSelect[bus_area_config_pkg::POS_AREA1_WIDTH +: 12]; // see RULE16
    next_cur.upper_data_port_en = cur.busWidthSelect[bus_area_config_pkg::BIT_PORT_EN]; // see RULE17

    // Settings software must not make
    badCfg = (next_cur.memType > bus_area_config_pkg::TYPE_BOTH_DRAM); // see RULE9
    for (int a = 0; a < 6; a++) begin
      w = cur.busWidthSelect[bus_area_config_pkg::POS_AREA1_WIDTH + 2 * a +: 2];
      if (w == bus_area_config_pkg::WIDTH_RSVD) begin
        badCfg = 1'b1; // see RULE16
      end
      if (next_cur.upper_data_port_en && (w == bus_area_config_pkg::WIDTH_32)) begin
        badCfg = 1'b1; // see RULE17
      end
    end
    if (next_cur.secondRas
        && ((cur.busWidthSelect[5:4] != bus_area_config_pkg::WIDTH_16)
        || (cur.busWidthSelect[7:6] != bus_area_config_pkg::WIDTH_16))) begin
      badCfg = 1'b1; // see RULE10
    end
    if (bus_area_config_pkg::burst_bad(
          cur.busAreaControl[bus_area_config_pkg::POS_AREA5_BURST +: 2],
          cur.busWidthSelect[11:10])
        || bus_area_config_pkg::burst_bad(
          cur.busAreaControl[bus_area_config_pkg::POS_AREA6_BURST +: 2],
          cur.busWidthSelect[13:12])) begin
      badCfg = 1'b1; // see RULE7 RULE8
    end
    next_cur.cfgErr = badCfg;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '0;
      cur.busAreaControl <= bus_area_config_pkg::RST_BUS_AREA_CONTROL; // see RULE13
      cur.busWidthSelect <= bus_area_config_pkg::RST_BUS_WIDTH_SELECT; // see RULE14
      cur.idleCycleControl <= bus_area_config_pkg::RST_IDLE_CYCLE_CONTROL; // see RULE21
      cur.widths <= 12'hFFF;
      cur.bigEnd <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Idle spacing between accesses
  // ----------------------------------------------------------------
  idle_gap_timer u_gap (
    .clock       (clock),
    .rst         (rst),
    .idleFields  (cur.idleCycleControl[13:0]),
    .accessReq   (accessReq),
    .accessArea  (accessArea),
    .accessWrite (accessWrite),
    .accessGrant (accessGrant)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata                     = cur.rdata;
  assign pready                     = cur.ready;
  assign pslverr                    = cur.err;
  assign busClockOut                = cur.busClk;
  assign waitSampled                = cur.waitSmp;
  assign memPinsOe                  = cur.memOe;
  assign dramStrobeOe               = cur.dramOe;
  assign bigEndian                  = cur.bigEnd;
  assign strapIsSecondRowStrobe     = cur.secondRas;
  assign thirdModePinIsCardEnableA  = cur.ceA;
  assign fourthModePinIsCardEnableB = cur.ceB;
  assign area0BurstLen              = cur.burst0;
  assign area5BurstLen              = cur.burst5;
  assign area6BurstLen              = cur.burst6;
  assign area23MemType              = cur.memType;
  assign areaWidths                 = cur.widths;
  assign upperDataPortEn            = cur.upper_data_port_en;
  assign configError                = cur.cfgErr;

endmodule

//--- bus_area_config_chk.sv
/*
  Concurrent checks on the bus area configuration block.
  Assumes one clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
module bus_area_config_chk (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        standby,
  input wire logic        busReleased,
  input wire logic        accessReq,
  input wire logic        accessGrant,
  input wire logic        busClockOut,
  input wire logic        memPinsOe,
  input wire logic        dramStrobeOe,
  input wire logic        strapIsSecondRowStrobe,
  input wire logic [2:0]  area23MemType,
  input wire logic        thirdModePinIsCardEnableA,
  input wire logic        fourthModePinIsCardEnableB
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  sequence ctrlWrite;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  sequence reqTaken;
    $rose(accessReq);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  mem_float_a: assert property (!rst && !standby |=> memPinsOe)
    else $error("memory pins float outside standby");
  dram_float_a: assert property (!rst && !standby && !busReleased |=> dramStrobeOe)
    else $error("strobes float while bus owned");
  card_a_sel_a: assert property (ctrlWrite |-> ##2 thirdModePinIsCardEnableA == $past(pwdata[1], 2))
    else $error("card enable A select wrong");
  card_b_sel_a: assert property (ctrlWrite |-> ##2 fourthModePinIsCardEnableB == $past(pwdata[0], 2))
    else $error("card enable B select wrong");
  mem_type_a: assert property (ctrlWrite |-> ##2 area23MemType == $past(pwdata[4:2], 2))
    else $error("memory type not taken");
  second_strobe_a: assert property (ctrlWrite |-> ##2
    strapIsSecondRowStrobe == ($past(pwdata[4:2], 2) == 3'h5))
    else $error("second row strobe mismatch");
  bus_clk_toggle_a: assert property (!rst && !$past(rst)
    |-> busClockOut != $past(busClockOut))
    else $error("bus clock not toggling");
  reserved_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000
    && (paddr != 8'h04 || (prdata[15:14] == 2'h0 && !prdata[1])))
    else $error("reserved bits not zero");
  grant_bound_a: assert property (reqTaken |-> ##[1:4] accessGrant)
    else $error("grant later than three idles");
  grant_pulse_a: assert property (accessGrant |=> !accessGrant)
    else $error("grant longer than one cycle");
endmodule

bind bus_area_config bus_area_config_chk chk_u (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .standby(standby), .busReleased(busReleased),
  .accessReq(accessReq), .accessGrant(accessGrant), .busClockOut(busClockOut),
  .memPinsOe(memPinsOe),
  .dramStrobeOe(dramStrobeOe), .strapIsSecondRowStrobe(strapIsSecondRowStrobe),
  .area23MemType(area23MemType), .thirdModePinIsCardEnableA(thirdModePinIsCardEnableA),
  .fourthModePinIsCardEnableB(fourthModePinIsCardEnableB)
);

//--- bus_area_config_pkg.sv
/*
  Constants, field positions and decoders for the bus area configuration
  registers. Assumes a 32-bit APB slave holding 16-bit registers.
*/
package bus_area_config_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFS_BUS_AREA_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_BUS_WIDTH_SELECT   = 8'h04;
  localparam logic [7:0]  OFS_IDLE_CYCLE_CONTROL = 8'h08;

  localparam logic [15:0] RST_BUS_AREA_CONTROL   = 16'h0000;
  localparam logic [15:0] RST_BUS_WIDTH_SELECT   = 16'h3FFC;
  localparam logic [15:0] RST_IDLE_CYCLE_CONTROL = 16'h3FFF;

  // Writable bits; the rest read zero, except the byte-order bit, which reads the strap
  localparam logic [15:0] MASK_BUS_AREA_CONTROL   = 16'h37FF;
  localparam logic [15:0] MASK_BUS_WIDTH_SELECT   = 16'h3FFD;
  localparam logic [15:0] MASK_IDLE_CYCLE_CONTROL = 16'hBFFF;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_MEM_FLOAT    = 13;
  localparam int BIT_DRAM_FLOAT   = 12;
  localparam int BIT_BYTE_ORDER   = 11;
  localparam int POS_AREA0_BURST  = 9;
  localparam int POS_AREA5_BURST  = 7;
  localparam int POS_AREA6_BURST  = 5;
  localparam int POS_AREA23_TYPE  = 2;
  localparam int BIT_AREA5_CARD   = 1;
  localparam int BIT_AREA6_CARD   = 0;
  localparam int BIT_PORT_EN      = 0;
  localparam int POS_AREA1_WIDTH  = 2;
  localparam int BIT_WAIT_EDGE    = 15;
  localparam int NUM_AREAS        = 7;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_RSVD = 2'h0;
  localparam logic [1:0] WIDTH_8    = 2'h1;
  localparam logic [1:0] WIDTH_16   = 2'h2;
  localparam logic [1:0] WIDTH_32   = 2'h3;

  localparam logic [2:0] TYPE_NORMAL      = 3'h0;
  localparam logic [2:0] TYPE_A3_PSRAM    = 3'h1;
  localparam logic [2:0] TYPE_A3_SDRAM    = 3'h2;
  localparam logic [2:0] TYPE_BOTH_SDRAM  = 3'h3;
  localparam logic [2:0] TYPE_A3_DRAM     = 3'h4;
  localparam logic [2:0] TYPE_BOTH_DRAM   = 3'h5;

  localparam logic [4:0] BURST_NONE = 5'h00;
  localparam logic [4:0] BURST_4    = 5'h04;
  localparam logic [4:0] BURST_8    = 5'h08;
  localparam logic [4:0] BURST_16   = 5'h10;

  // Burst length from a two-bit burst field
  function automatic logic [4:0] burst_len(input logic [1:0] code);
    case (code)
      2'h1:    burst_len = BURST_4;
      2'h2:    burst_len = BURST_8;
      2'h3:    burst_len = BURST_16;
      default: burst_len = BURST_NONE;
    endcase
  endfunction

  // Burst setting that the area width cannot carry
  function automatic logic burst_bad(input logic [1:0] code, input logic [1:0] width);
    case (code)
      2'h1:    burst_bad = (width == WIDTH_RSVD);
      2'h2:    burst_bad = (width != WIDTH_8) && (width != WIDTH_16);
      2'h3:    burst_bad = (width != WIDTH_8);
      default: burst_bad = 1'b0;
    endcase
  endfunction

  // Idle cycles from a two-bit idle field
  function automatic logic [1:0] idle_cycles(input logic [1:0] code);
    case (code)
      2'h2:    idle_cycles = 2'h2;
      2'h3:    idle_cycles = 2'h3;
      default: idle_cycles = 2'h1;
    endcase
  endfunction

endpackage

//--- ext_wait_source.sv
/*
  External memory wait source on the far side of the bus.
  Assumes busClockOut low means a bus clock rising edge follows.
*/
`timescale 1ns/1ps
module ext_wait_source (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic busClockOut,
  input  wire logic slow,
  output logic      waitIn
);
  logic [2:0] phase;
  // Wait changes only with the bus clock; idle when prompt
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      phase  <= 3'h0;
      waitIn <= 1'b0;
    end else if (busClockOut) begin
      phase <= phase + 3'h1;
      if (phase == 3'h7) begin
        waitIn <= slow & ~waitIn;
      end
    end
  end
endmodule

//--- idle_gap_timer.sv
/*
  Spaces external accesses by the programmed idle cycles.
  Assumes a requester that holds its request until the grant pulse.
*/
`timescale 1ns/1ps
module idle_gap_timer (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [13:0] idleFields,
  input  wire logic        accessReq,
  input  wire logic [2:0]  accessArea,
  input  wire logic        accessWrite,
  output logic             accessGrant
);

  typedef enum logic [0:0] {GAP_IDLE, GAP_WAIT} gap_state_t;

  typedef struct packed {
    gap_state_t state;
    logic [1:0] count;
    logic [2:0] lastArea;
    logic       lastRead;
    logic       seen;
    logic       grant;
  } gap_t;

  gap_t cur;
  gap_t next_cur;
  logic needGap;
  logic [1:0] gapLen;

  always_comb begin
    next_cur = cur;
    next_cur.grant = 1'b0;
    // Gap on change of area, or read followed by write
    needGap = cur.seen && ((accessArea != cur.lastArea) || (cur.lastRead && accessWrite)); // see RULE19
    gapLen = bus_area_config_pkg::idle_cycles(idleFields[2 * cur.lastArea +: 2]); // see RULE20
    case (cur.state)
      GAP_IDLE: begin
        if (accessReq && !cur.grant) begin
          if (needGap) begin
            next_cur.state = GAP_WAIT;
            next_cur.count = gapLen;
          end else begin
            next_cur.grant = 1'b1;
            next_cur.lastArea = accessArea;
            next_cur.lastRead = !accessWrite;
            next_cur.seen = 1'b1;
          end
        end
      end
      GAP_WAIT: begin
        if (cur.count > 2'h1) begin
          next_cur.count = cur.count - 2'h1;
        end else begin
          next_cur.state = GAP_IDLE;
          next_cur.count = 2'h0;
          next_cur.grant = 1'b1;
          next_cur.lastArea = accessArea;
          next_cur.lastRead = !accessWrite;
          next_cur.seen = 1'b1;
        end
      end
      default: next_cur.state = GAP_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur <= '{state: GAP_IDLE, count: 2'h0, lastArea: 3'h0, lastRead: 1'b0,
               seen: 1'b0, grant: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign accessGrant = cur.grant;

endmodule

//--- tb_top.sv
/*
  Self-checking bench for the bus area configuration block.
  Assumes the APB slave answers in its own time, read data in low half.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst, psel, penable, pwrite, manualReset, standby;
  logic        busReleased, strap, accessReq, accessWrite, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  accessArea, memType;
  logic        pready, pslverr, accessGrant, busClockOut, waitSampled, waitIn;
  logic        memPinsOe, dramStrobeOe, bigEndian, strapRs, cardA, cardB, upper_data_port_en, cfgErr;
  logic [4:0]  b0, b5, b6;
  logic [11:0] areaWidths;
  logic [17:0] expQ[$];
  logic [17:0] expNow;
  logic [15:0] shadow[3];
  logic [15:0] rnd, w;
  logic [15:0] wv[4] = '{16'h3FFD, 16'h2AA9, 16'h3FF0, 16'h3FAC};
  integer      seed;
  int          errTotal, cmpCount, i, k, s, a;

  bus_area_config dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .manualReset(manualReset), .standby(standby),
    .busReleased(busReleased), .byteOrderStrapPin(strap), .waitIn(waitIn),
    .accessReq(accessReq), .accessArea(accessArea), .accessWrite(accessWrite),
    .accessGrant(accessGrant), .busClockOut(busClockOut), .waitSampled(waitSampled),
    .memPinsOe(memPinsOe), .dramStrobeOe(dramStrobeOe), .bigEndian(bigEndian),
    .strapIsSecondRowStrobe(strapRs), .thirdModePinIsCardEnableA(cardA),
    .fourthModePinIsCardEnableB(cardB), .area0BurstLen(b0), .area5BurstLen(b5),
    .area6BurstLen(b6), .area23MemType(memType), .areaWidths(areaWidths),
    .upperDataPortEn(upper_data_port_en), .configError(cfgErr));
  ext_wait_source far_u (.clock(clock), .rst(rst), .busClockOut(busClockOut),
    .slow(slow), .waitIn(waitIn));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task summarize;
    $display("errors %0d compares %0d", errTotal, cmpCount);
    if (errTotal == 0 && cmpCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task miss(input string m);
    errTotal++;
    $display("mismatch at %0t: %s", $time, m);
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    cmpCount++;
    if (got !== exp) miss(m);
  endtask
  task settle;
    repeat (2) @(posedge clock);
    #1;
  endtask
  function automatic logic [15:0] msk(input int r);
    case (r)
      0: msk = bus_area_config_pkg::MASK_BUS_AREA_CONTROL;
      1: msk = bus_area_config_pkg::MASK_BUS_WIDTH_SELECT;
      default: msk = bus_area_config_pkg::MASK_IDLE_CYCLE_CONTROL;
    endcase
  endfunction
  task doReset;
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    shadow = '{16'h0000, 16'h3FFC, 16'h3FFF};
    repeat (2) @(posedge clock);
    #1;
  endtask
  task apb(input logic wr, input int r, input logic [15:0] d);
    logic ev;
    ev = (r > 2);
    if (wr) begin
      expQ.push_back({1'b0, ev, 16'h0000});
      if (!ev) shadow[r] = d & msk(r);
    end else begin
      expQ.push_back({1'b1, ev, ev ? 16'h0000 : shadow[r] | ((r == 0 && strap) ? 16'h0800 : 16'h0000)});
    end
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= 8'(r * 4); pwdata <= {16'h0000, d};
    @(posedge clock);
    penable <= 1'b1;
    a = 0;
    do begin @(posedge clock); a++; end while (pready !== 1'b1 && a < 12);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin miss("bus hang"); summarize; end
  endtask
  task access(input logic [2:0] ar, input logic wr, input int lat);
    @(posedge clock);
    accessReq <= 1'b1; accessArea <= ar; accessWrite <= wr;
    a = 0;
    do begin @(posedge clock); #1; a++; end while (accessGrant !== 1'b1 && a < 12);
    @(posedge clock);
    accessReq <= 1'b0;
    if (a >= 12) begin miss("grant hang"); summarize; end
    if (lat > 0) chk(16'(a), 16'(lat), "grant delay");
  endtask

  // Read results matched against the oldest expectation
  always @(posedge clock) begin
    if (pready === 1'b1) begin
      if (expQ.size() == 0) miss("unexpected answer");
      else begin
        expNow = expQ.pop_front();
        chk(16'(pslverr), 16'(expNow[16]), "slave error");
        if (expNow[17]) chk(prdata[15:0], expNow[15:0], "read data");
      end
    end
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hCFA3; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; manualReset = 1'b0; standby = 1'b0;
    busReleased = 1'b0; strap = 1'b1; accessReq = 1'b0; accessArea = 3'h0;
    accessWrite = 1'b0; slow = 1'b0; errTotal = 0; cmpCount = 0;
    doReset;
    chk(16'(bigEndian), 16'h0000, "endian flag");
    for (i = 0; i < 4; i++) apb(1'b0, i, 16'h0000);
    for (i = 0; i < 3; i++) repeat (3) begin
      rnd = 16'($random(seed));
      apb(1'b1, i, rnd);
      apb(1'b0, i, 16'h0000);
    end
    apb(1'b1, 3, 16'hFFFF);
    @(posedge clock) begin manualReset <= 1'b1; standby <= 1'b1; end
    repeat (4) @(posedge clock);
    manualReset <= 1'b0;
    standby <= 1'b0;
    for (i = 0; i < 3; i++) apb(1'b0, i, 16'h0000);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 0, 16'(k << 12));
      for (s = 0; s < 4; s++) begin
        @(posedge clock) {standby, busReleased} <= 2'(s);
        settle;
        chk(16'(memPinsOe), 16'(!standby || k[1]), "memory float");
        chk(16'(dramStrobeOe), 16'(!(standby|busReleased)||k[0]), "strobe float");
      end
    end
    @(posedge clock) {standby, busReleased} <= 2'h0;
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 1, wv[k]);
      settle;
      chk({4'h0, areaWidths}, {4'h0, wv[k][13:2]}, "width fields");
      chk(16'(upper_data_port_en), 16'(wv[k][0]), "port enable");
      chk(16'(cfgErr), 16'(k == 0 || k == 2), "width error");
    end
    for (k = 0; k < 8; k++) begin
      apb(1'b1, 0, 16'(k << 2));
      settle;
      chk(16'(memType), 16'(k), "memory type");
      chk(16'(strapRs), 16'(k == 5), "second strobe");
      chk(16'(cfgErr), 16'(k >= 6), "type error");
    end
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 0, 16'(k));
      settle;
      chk(16'({cardA, cardB}), 16'(k), "card space");
      apb(1'b1, 0, 16'((k << 9) | (k << 7) | (k << 5)));
      settle;
      w = 16'(k == 0 ? 0 : 2 << k);
      chk(16'(b0), w, "area0 burst");
      chk(16'(b5), w, "area5 burst");
      chk(16'(b6), w, "area6 burst");
      chk(16'(cfgErr), 16'(k >= 2), "burst error");
    end
    for (k = 0; k < 4; k++) begin
      apb(1'b1, 2, 16'h3FF3 | 16'(k << 2));
      access(3'h1, 1'b0, 0);
      access(3'h2, 1'b0, k < 2 ? 2 : k + 1);
      access(3'h2, 1'b0, 1);
      access(3'h2, 1'b1, 4);
    end
    slow <= 1'b1;
    for (k = 0; k < 2; k++) begin
      apb(1'b1, 2, 16'h3FFF | 16'(k << 15));
      w = 16'(waitIn);
      s = 0;
      repeat (80) begin
        @(posedge clock);
        #1;
        s = (16'(waitIn) === w) ? s + 1 : 0;
        w = 16'(waitIn);
        if (s == 4) chk(16'(waitSampled), w, "wait sample");
      end
    end
    strap <= 1'b0;
    doReset;
    apb(1'b0, 0, 16'h0000);
    chk(16'(bigEndian), 16'h0001, "endian flag");
    settle;
    summarize;
  end
endmodule
